/* bench/comm_verify_write_protect_crc_tb.sv */
`timescale 1ns/1ps
module comm_verify_write_protect_crc_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic soft_reset = 1'b0;
	logic acc_valid, acc_write, acc_done, acc_ok, checksum_enabled, irq_n, ok;
	logic [15:0] acc_addr;
	logic [31:0] acc_wdata, acc_rdata, rd, c1, c2;
	int err_count = 0;
	int cmp_count = 0;
	always #12.5 core_clk = ~core_clk;
	cvw_reg_bank dut (.core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset), .acc_valid(acc_valid),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_ok(acc_ok),
		.acc_rdata(acc_rdata), .checksum_enabled(checksum_enabled), .irq_n(irq_n));
	cvw_host host (.core_clk(core_clk), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_ok(acc_ok), .acc_rdata(acc_rdata));
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_ok(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t status %b expected %b", $time, got, exp);
		end
	endtask : chk_ok
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic exp);
		host.xfer(1'b1, a, d, ok, rd);
		chk_ok(ok, exp);
	endtask : wr
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, ok, rd);
		chk_ok(ok, 1'b1);
		chk_val(rd, exp);
	endtask : rd_chk
	task automatic pulse_soft_reset;
		@(posedge core_clk);
		#2;
		soft_reset = 1'b1;
		@(posedge core_clk);
		#2;
		soft_reset = 1'b0;
	endtask : pulse_soft_reset
	// Covered image, first shifted bit at index 0: mode, gains, config, dividers, select, phases,
	// alternate output, accumulation, both enables, calibrations and reserved bytes.
	function automatic logic [31:0] crc_img(input logic [15:0] cfg, input logic [23:0] irqa);
		logic [767:0] img;
		logic [31:0] c;
		img = {552'h0, 24'h0, irqa, 24'h0, 48'h0, 16'h0300, 16'h003f, 16'h003f, cfg, 24'h0, 8'h40};
		c = 32'hffffffff;
		for (int i = 0; i < 768; i++) c = (c >> 1) ^ ((c[0] ^ img[i]) ? 32'hedb88320 : 32'h0);
		return ~c;
	endfunction : crc_img
	task automatic t_defaults;
		rd_chk(16'h0040, 32'h0);
		rd_chk(16'h0004, 32'h40);
		rd_chk(16'h0102, 32'h8004);
		rd_chk(16'h0107, 32'h0300);
		rd_chk(16'h037f, 32'hfffffffe);
		host.xfer(1'b0, 16'h0005, 32'h0, ok, rd);
		chk_ok(ok, 1'b0);
	endtask : t_defaults
	task automatic t_lock;
		logic [15:0] a [4] = '{16'h0007, 16'h0103, 16'h0281, 16'h0381};
		logic [7:0] m [4] = '{8'h01, 8'h02, 8'h04, 8'h04};
		for (int i = 0; i < 4; i++) begin
			wr(a[i], 32'h5 + i, 1'b1);
			wr(16'h0040, {24'h0, m[i]}, 1'b1);
			wr(a[i], 32'h3c, 1'b0);
			rd_chk(a[i], 32'h5 + i);
			wr(16'h0040, 32'h0, 1'b1);
			wr(a[i], 32'h9, 1'b1);
			rd_chk(a[i], 32'h9);
		end
		wr(16'h0040, 32'hff, 1'b1);
		rd_chk(16'h0040, 32'h07);
		wr(16'h0040, 32'h0, 1'b1);
	endtask : t_lock
	task automatic t_verify;
		wr(16'h0108, 32'h1234, 1'b1);
		rd_chk(16'h00fd, 32'hca);
		rd_chk(16'h01fe, 32'h00fd);
		rd_chk(16'h01ff, 32'h00fd);
		wr(16'h037f, 32'h1, 1'b0);
		rd_chk(16'h00fd, 32'h35);
		rd_chk(16'h01fe, 32'h00fd);
		wr(16'h0108, 32'h1234, 1'b1);
		rd_chk(16'h03ff, 32'h1234);
		rd_chk(16'h00ff, 32'h34);
		rd_chk(16'h02ff, 32'h34);
	endtask : t_verify
	task automatic t_alias;
		wr(16'h0285, 32'h800001, 1'b1);
		rd_chk(16'h0385, 32'hff800001);
		wr(16'h0386, 32'h123456, 1'b1);
		rd_chk(16'h0286, 32'h123456);
	endtask : t_alias
	task automatic t_checksum;
		pulse_soft_reset();
		rd_chk(16'h0108, 32'h0);
		rd_chk(16'h0285, 32'h0);
		wr(16'h0102, 32'h8104, 1'b1);
		chk_ok(checksum_enabled, 1'b1);
		host.poll_change(32'hfffffffe, c1);
		chk_val(c1, crc_img(16'h8104, 24'h0));
		chk_ok(irq_n, 1'b1);
		wr(16'h022c, 32'h200000, 1'b1);
		host.poll_change(c1, c2);
		chk_val(c2, crc_img(16'h8104, 24'h200000));
		for (int k = 0; k < 1000 && irq_n !== 1'b0; k++) @(posedge core_clk);
		chk_ok(irq_n, 1'b0);
		wr(16'h0102, 32'h8004, 1'b1);
		chk_ok(checksum_enabled, 1'b0);
		rd_chk(16'h037f, 32'hfffffffe);
		pulse_soft_reset();
		@(posedge core_clk);
		chk_ok(irq_n, 1'b1);
		rd_chk(16'h022c, 32'h0);
	endtask : t_checksum
	task automatic end_sim;
		$display("errors %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#2500000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#2;
		rst_n = 1'b1;
		t_defaults();
		t_lock();
		t_verify();
		t_alias();
		t_checksum();
		end_sim();
	end
endmodule : comm_verify_write_protect_crc_tb

/* bench/cvw_host.sv */
`timescale 1ns/1ps
module cvw_host (
	input wire logic core_clk,
	output logic acc_valid,
	output logic acc_write,
	output logic [15:0] acc_addr,
	output logic [31:0] acc_wdata,
	input wire logic acc_done,
	input wire logic acc_ok,
	input wire logic [31:0] acc_rdata
);
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_addr = 16'h0000;
		acc_wdata = 32'h00000000;
	end
	// A missing answer comes back as an unknown status so that any compare on it fails.
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic ok,
		output logic [31:0] rd);
		@(posedge core_clk);
		#2;
		acc_valid = 1'b1;
		acc_write = wr;
		acc_addr = a;
		acc_wdata = d;
		@(posedge core_clk);
		#2;
		acc_valid = 1'b0;
		acc_addr = ~a;
		acc_wdata = ~d;
		ok = (acc_done === 1'b1) ? acc_ok : 1'bx;
		rd = acc_rdata;
	endtask : xfer
	// Polls the checksum until it moves away from the previous reading.
	task automatic poll_change(input logic [31:0] old, output logic [31:0] now);
		logic ok;
		now = old;
		for (int k = 0; k < 200 && now === old; k++) begin
			repeat (8) @(posedge core_clk);
			xfer(1'b0, 16'h037f, 32'h0, ok, now);
		end
	endtask : poll_change
endmodule : cvw_host

/* bench/cvw_reg_bank_monitor.sv */
`timescale 1ns/1ps
module cvw_reg_bank_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [15:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	input wire logic acc_done,
	input wire logic acc_ok,
	input wire logic [31:0] acc_rdata,
	input wire logic checksum_enabled,
	input wire logic irq_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n || soft_reset);
	property p_answer; acc_valid |=> acc_done; endproperty
	a_answer: assert property (p_answer) else $error("no answer after request");
	property p_stray; !acc_valid |=> !acc_done && !acc_ok; endproperty
	a_stray: assert property (p_stray) else $error("answer without request");
	property p_wr_data; acc_valid && acc_write |=> acc_rdata == 32'h0; endproperty
	a_wr_data: assert property (p_wr_data) else $error("read data on write");
	property p_ro; acc_valid && acc_write && (acc_addr == 16'h037f || acc_addr == 16'h01fe) |=> !acc_ok; endproperty
	a_ro: assert property (p_ro) else $error("read-only write accepted");
	property p_lock_w; acc_valid && !acc_write && acc_addr == 16'h0040
		|=> acc_ok && acc_rdata[31:3] == 29'h0; endproperty
	a_lock_w: assert property (p_lock_w) else $error("lock register upper bits set");
	property p_idle; (!checksum_enabled)[*2] ##0 (acc_valid && !acc_write && acc_addr == 16'h037f)
		|=> acc_rdata == 32'hfffffffe; endproperty
	a_idle: assert property (p_idle) else $error("checksum not idle value");
	property p_rst; $rose(rst_n) |-> irq_n && !acc_done; endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	property p_soft; disable iff (!rst_n) soft_reset |=> irq_n && !acc_done && !checksum_enabled; endproperty
	a_soft: assert property (p_soft) else $error("soft reset ineffective");
	property p_op; acc_valid && !acc_write && acc_addr == 16'h00fd
		|=> acc_ok && acc_rdata[7:0] inside {8'hca, 8'h35, 8'h00}; endproperty
	a_op: assert property (p_op) else $error("bad operation code");
	property p_unmap; acc_valid && acc_addr == 16'h0005 |=> acc_done && !acc_ok; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
	c_write: cover property (acc_valid && acc_write ##1 acc_ok);
	c_refused: cover property (acc_valid && acc_write ##1 !acc_ok);
	c_irq: cover property ($fell(irq_n));
endmodule : cvw_reg_bank_monitor
bind cvw_reg_bank cvw_reg_bank_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset),
	.acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
	.acc_ok(acc_ok), .acc_rdata(acc_rdata), .checksum_enabled(checksum_enabled), .irq_n(irq_n));

/* rtl/cvw_crc_engine.sv */
`timescale 1ns/1ps
module cvw_crc_engine (
	input wire logic core_clk,
	input wire logic rst_n,
	cvw_crc_if.engine crc
);
	logic [31:0] lfsr;
	logic feedback;

	assign feedback = lfsr[0] ^ crc.bit_in;

	// Reflected CRC-32 register, fed one bit per clock, least significant bit first.
	always_ff @(posedge core_clk) begin
		if (!rst_n || crc.clear) begin
			lfsr <= cvw_pkg::CRC_INIT;
		end else if (crc.shift) begin
			lfsr <= (lfsr >> 1) ^ (feedback ? cvw_pkg::CRC_POLY_REFLECTED : 32'h00000000);
		end
	end

	assign crc.value = ~lfsr;
endmodule : cvw_crc_engine

/* rtl/cvw_crc_if.sv */
`timescale 1ns/1ps
interface cvw_crc_if;
	logic clear;
	logic shift;
	logic bit_in;
	logic [31:0] value;
	modport engine (input clear, input shift, input bit_in, output value);
	modport seq (output clear, output shift, output bit_in, input value);
endinterface : cvw_crc_if

/* rtl/cvw_pkg.sv */
// Behaviour
// - Write-lock register is eight bits wide; only its three low bits do anything.
// - Lock bit 0 guards 8-bit, bit 1 16-bit, bit 2 24/32-bit registers.
// - Reset clears all lock bits so every register group accepts writes.
// - A write to a locked group is discarded, whichever serial port carried it.
// - Clearing a lock bit restores write access to its group at once.
// - Each successful access loads its address into the 16-bit last-address register.
// - Last-operation register reads 0xca after a write, 0x35 after a read.
// - Last transfer data is readable at 0x0ff, 0x1ff, 0x2ff and 0x3ff by width.
// - Last transfer data holds the value written or returned by the last success.
// - Failed accesses leave last operation, address and data unchanged.
// - A 32-bit read-only checksum register sits at address 0x37f.
// - The checksum is the Ethernet CRC-32 built with a shift register.
// - Covered registers shift in one after another, each LSB first.
// - Six internal reserved registers are also covered by the checksum.
// - Covered set: mode, gains, config, dividers, select, phases, alternate output, accumulation, enables, all calibrations.
// - Checksum is off after reset and runs only while config bit 8 is set.
// - While disabled the checksum register reads 0xfffffffe.
// - Hardware or software reset returns every register to its default.
// - Checksum interrupt is off after reset, enabled by bit 21 at 0x22c/0x32c.
// - Once enabled, the interrupt pin drops while the checksum differs from its snapshot.
// - A 24-bit register and its 32-bit alias share one storage location.
package cvw_pkg;
	localparam logic [15:0] ADDR_LINE_CYCLE_MODE = 16'h0004;
	localparam logic [15:0] ADDR_VOLTAGE_GAIN = 16'h0007;
	localparam logic [15:0] ADDR_CURRENT_A_GAIN = 16'h0008;
	localparam logic [15:0] ADDR_CURRENT_B_GAIN = 16'h0009;
	localparam logic [15:0] ADDR_BANK_WRITE_LOCK = 16'h0040;
	localparam logic [15:0] ADDR_LAST_OPERATION_TYPE = 16'h00fd;
	localparam logic [15:0] ADDR_LAST_DATA_BYTE = 16'h00ff;
	localparam logic [15:0] ADDR_CONFIG = 16'h0102;
	localparam logic [15:0] ADDR_PULSE1_DIVIDER = 16'h0103;
	localparam logic [15:0] ADDR_PULSE2_DIVIDER = 16'h0104;
	localparam logic [15:0] ADDR_PULSE_OUTPUT_SELECT = 16'h0107;
	localparam logic [15:0] ADDR_PHASE_CAL_A = 16'h0108;
	localparam logic [15:0] ADDR_PHASE_CAL_B = 16'h0109;
	localparam logic [15:0] ADDR_ALTERNATE_OUTPUT = 16'h0110;
	localparam logic [15:0] ADDR_LAST_ACCESSED_ADDRESS = 16'h01fe;
	localparam logic [15:0] ADDR_LAST_DATA_HALF = 16'h01ff;
	localparam logic [15:0] ADDR_LAST_DATA_TRIPLE = 16'h02ff;
	localparam logic [15:0] ADDR_CONFIG_CHECKSUM = 16'h037f;
	localparam logic [15:0] ADDR_LAST_DATA_WORD = 16'h03ff;
	// Low byte of the 24-bit registers; the alias bank adds 0x100.
	localparam logic [7:0] LOW_ACCUMULATION_MODE = 8'h01;
	localparam logic [7:0] LOW_CHANNEL_A_IRQ_ENABLE = 8'h2c;
	localparam logic [7:0] LOW_CHANNEL_B_IRQ_ENABLE = 8'h2f;
	localparam logic [7:0] LOW_CAL_BASE = 8'h80;
	localparam int CAL_COUNT = 24;
	localparam logic [CAL_COUNT-1:0] CAL_PRESENT = 24'he7dfff;
	localparam logic [1:0] BANK_8 = 2'h0;
	localparam logic [1:0] BANK_16 = 2'h1;
	localparam logic [1:0] BANK_24 = 2'h2;
	localparam logic [1:0] BANK_32 = 2'h3;
	localparam int LOCK_BIT_8 = 0;
	localparam int LOCK_BIT_16 = 1;
	localparam int LOCK_BIT_WIDE = 2;
	localparam int LOCK_WIDTH = 3;
	localparam int CHECKSUM_ENABLE_BIT = 8;
	localparam int CHECKSUM_IRQ_BIT = 21;
	localparam logic [7:0] OP_WRITE = 8'hca;
	localparam logic [7:0] OP_READ = 8'h35;
	localparam logic [7:0] RESET_LINE_CYCLE_MODE = 8'h40;
	localparam logic [7:0] RESET_GAIN = 8'h00;
	localparam logic [7:0] RESET_LAST_OPERATION = 8'h00;
	localparam logic [15:0] RESET_CONFIG = 16'h8004;
	localparam logic [15:0] RESET_PULSE_DIVIDER = 16'h003f;
	localparam logic [15:0] RESET_PULSE_OUTPUT_SELECT = 16'h0300;
	localparam logic [15:0] RESET_HALF = 16'h0000;
	localparam logic [23:0] RESET_TRIPLE = 24'h000000;
	localparam logic [31:0] RESET_CHECKSUM = 32'hfffffffe;
	localparam logic [31:0] CRC_POLY_REFLECTED = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam int RESERVED_COUNT = 6;
	localparam logic [8*RESERVED_COUNT-1:0] RESERVED_IMAGE = 48'h000000000000;
	localparam int IMAGE_WIDTH = 4 * 8 + 7 * 16 + 3 * 24 + 21 * 24 + 8 * RESERVED_COUNT;
endpackage : cvw_pkg

/* rtl/cvw_reg_bank.sv */
`timescale 1ns/1ps
module cvw_reg_bank (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic soft_reset,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [15:0] acc_addr,
	input wire logic [31:0] acc_wdata,
	output logic acc_done,
	output logic acc_ok,
	output logic [31:0] acc_rdata,
	output logic checksum_enabled,
	output logic irq_n
);
	typedef enum {CVW_IDLE, CVW_RUN, CVW_FINISH} cvw_state_t;
	localparam int IDX_W = $clog2(cvw_pkg::IMAGE_WIDTH);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(cvw_pkg::IMAGE_WIDTH - 1);

	logic clear_all;
	logic [7:0] line_cycle_mode;
	logic [7:0] voltage_gain_select;
	logic [7:0] current_a_gain_select;
	logic [7:0] current_b_gain_select;
	logic [cvw_pkg::LOCK_WIDTH-1:0] bank_write_lock;
	logic [15:0] config_reg;
	logic [15:0] pulse1_divider;
	logic [15:0] pulse2_divider;
	logic [15:0] pulse_output_select;
	logic [15:0] phase_cal_a;
	logic [15:0] phase_cal_b;
	logic [15:0] alternate_output_select;
	logic [23:0] accumulation_mode;
	logic [23:0] channel_a_interrupt_enable;
	logic [23:0] channel_b_interrupt_enable;
	logic [23:0] cal_store [cvw_pkg::CAL_COUNT];
	logic [7:0] last_operation_type;
	logic [15:0] last_accessed_address;
	logic [31:0] last_transfer_data;
	logic [31:0] config_checksum;
	logic [31:0] irq_snapshot;
	logic irq_enable_q;
	logic [31:0] rd_value;
	logic rd_hit;
	logic wr_hit;
	logic locked;
	logic success;
	logic do_write;
	logic covered_write;
	logic dirty;
	logic [IDX_W-1:0] bit_idx;
	logic [cvw_pkg::IMAGE_WIDTH-1:0] image;
	cvw_state_t state;
	cvw_crc_if crc ();

	cvw_crc_engine u_crc (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.crc(crc)
	);

	assign clear_all = !rst_n || soft_reset;

	function automatic logic [31:0] sign_extend(input logic [23:0] v);
		sign_extend = {{8{v[23]}}, v};
	endfunction : sign_extend

	function automatic logic is_wide(input logic [15:0] a);
		is_wide = (a[15:10] == 6'h00) && (a[9:8] == cvw_pkg::BANK_24 || a[9:8] == cvw_pkg::BANK_32);
	endfunction : is_wide

	function automatic logic [31:0] widen(input logic [15:0] a, input logic [23:0] v);
		widen = (a[9:8] == cvw_pkg::BANK_32) ? sign_extend(v) : {8'h00, v};
	endfunction : widen

	function automatic int unsigned cal_index(input logic [7:0] low);
		cal_index = int'(low - cvw_pkg::LOW_CAL_BASE);
	endfunction : cal_index

	function automatic logic is_cal(input logic [7:0] low);
		logic in_range;
		in_range = (low >= cvw_pkg::LOW_CAL_BASE) && (low < cvw_pkg::LOW_CAL_BASE + 8'(cvw_pkg::CAL_COUNT));
		is_cal = in_range && cvw_pkg::CAL_PRESENT[5'(low - cvw_pkg::LOW_CAL_BASE)];
	endfunction : is_cal

	// Read decode; every mapped address is readable, writable ones also flag wr_hit.
	always_comb begin
		rd_value = 32'h00000000;
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		unique case (acc_addr)
			cvw_pkg::ADDR_LINE_CYCLE_MODE: rd_value = {24'h000000, line_cycle_mode};
			cvw_pkg::ADDR_VOLTAGE_GAIN: rd_value = {24'h000000, voltage_gain_select};
			cvw_pkg::ADDR_CURRENT_A_GAIN: rd_value = {24'h000000, current_a_gain_select};
			cvw_pkg::ADDR_CURRENT_B_GAIN: rd_value = {24'h000000, current_b_gain_select};
			cvw_pkg::ADDR_BANK_WRITE_LOCK: rd_value = {29'h00000000, bank_write_lock};
			cvw_pkg::ADDR_CONFIG: rd_value = {16'h0000, config_reg};
			cvw_pkg::ADDR_PULSE1_DIVIDER: rd_value = {16'h0000, pulse1_divider};
			cvw_pkg::ADDR_PULSE2_DIVIDER: rd_value = {16'h0000, pulse2_divider};
			cvw_pkg::ADDR_PULSE_OUTPUT_SELECT: rd_value = {16'h0000, pulse_output_select};
			cvw_pkg::ADDR_PHASE_CAL_A: rd_value = {16'h0000, phase_cal_a};
			cvw_pkg::ADDR_PHASE_CAL_B: rd_value = {16'h0000, phase_cal_b};
			cvw_pkg::ADDR_ALTERNATE_OUTPUT: rd_value = {16'h0000, alternate_output_select};
			cvw_pkg::ADDR_LAST_OPERATION_TYPE: begin
				rd_value = {24'h000000, last_operation_type};
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_LAST_ACCESSED_ADDRESS: begin
				rd_value = {16'h0000, last_accessed_address};
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_LAST_DATA_BYTE: begin
				rd_value = {24'h000000, last_transfer_data[7:0]};
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_LAST_DATA_HALF: begin
				rd_value = {16'h0000, last_transfer_data[15:0]};
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_LAST_DATA_TRIPLE: begin
				rd_value = {8'h00, last_transfer_data[23:0]};
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_LAST_DATA_WORD: begin
				rd_value = last_transfer_data;
				wr_hit = 1'b0;
			end
			cvw_pkg::ADDR_CONFIG_CHECKSUM: begin
				rd_value = config_checksum;
				wr_hit = 1'b0;
			end
			default: begin
				rd_hit = 1'b0;
				wr_hit = 1'b0;
				if (is_wide(acc_addr)) begin
					rd_hit = 1'b1;
					wr_hit = 1'b1;
					if (acc_addr[7:0] == cvw_pkg::LOW_ACCUMULATION_MODE) begin
						rd_value = widen(acc_addr, accumulation_mode);
					end else if (acc_addr[7:0] == cvw_pkg::LOW_CHANNEL_A_IRQ_ENABLE) begin
						rd_value = widen(acc_addr, channel_a_interrupt_enable);
					end else if (acc_addr[7:0] == cvw_pkg::LOW_CHANNEL_B_IRQ_ENABLE) begin
						rd_value = widen(acc_addr, channel_b_interrupt_enable);
					end else if (is_cal(acc_addr[7:0])) begin
						rd_value = widen(acc_addr, cal_store[cal_index(acc_addr[7:0])]);
					end else begin
						rd_hit = 1'b0;
						wr_hit = 1'b0;
					end
				end
			end
		endcase
	end

	// The lock register itself stays writable so software can always release a bank.
	always_comb begin
		locked = 1'b0;
		if (acc_addr != cvw_pkg::ADDR_BANK_WRITE_LOCK) begin
			unique case (acc_addr[9:8])
				cvw_pkg::BANK_8: locked = bank_write_lock[cvw_pkg::LOCK_BIT_8];
				cvw_pkg::BANK_16: locked = bank_write_lock[cvw_pkg::LOCK_BIT_16];
				cvw_pkg::BANK_24, cvw_pkg::BANK_32: locked = bank_write_lock[cvw_pkg::LOCK_BIT_WIDE];
			endcase
		end
	end

	assign success = acc_valid && (acc_write ? (wr_hit && !locked) : rd_hit);
	assign do_write = success && acc_write;
	assign covered_write = do_write && acc_addr != cvw_pkg::ADDR_BANK_WRITE_LOCK;

	// Configuration and calibration storage.
	always_ff @(posedge core_clk) begin
		if (clear_all) begin
			bank_write_lock <= '0;
			line_cycle_mode <= cvw_pkg::RESET_LINE_CYCLE_MODE;
			voltage_gain_select <= cvw_pkg::RESET_GAIN;
			current_a_gain_select <= cvw_pkg::RESET_GAIN;
			current_b_gain_select <= cvw_pkg::RESET_GAIN;
			config_reg <= cvw_pkg::RESET_CONFIG;
			pulse1_divider <= cvw_pkg::RESET_PULSE_DIVIDER;
			pulse2_divider <= cvw_pkg::RESET_PULSE_DIVIDER;
			pulse_output_select <= cvw_pkg::RESET_PULSE_OUTPUT_SELECT;
			phase_cal_a <= cvw_pkg::RESET_HALF;
			phase_cal_b <= cvw_pkg::RESET_HALF;
			alternate_output_select <= cvw_pkg::RESET_HALF;
			accumulation_mode <= cvw_pkg::RESET_TRIPLE;
			channel_a_interrupt_enable <= cvw_pkg::RESET_TRIPLE;
			channel_b_interrupt_enable <= cvw_pkg::RESET_TRIPLE;
			for (int i = 0; i < cvw_pkg::CAL_COUNT; i++) begin
				cal_store[i] <= cvw_pkg::RESET_TRIPLE;
			end
		end else if (do_write) begin
			unique case (acc_addr)
				cvw_pkg::ADDR_BANK_WRITE_LOCK: bank_write_lock <= acc_wdata[cvw_pkg::LOCK_WIDTH-1:0];
				cvw_pkg::ADDR_LINE_CYCLE_MODE: line_cycle_mode <= acc_wdata[7:0];
				cvw_pkg::ADDR_VOLTAGE_GAIN: voltage_gain_select <= acc_wdata[7:0];
				cvw_pkg::ADDR_CURRENT_A_GAIN: current_a_gain_select <= acc_wdata[7:0];
				cvw_pkg::ADDR_CURRENT_B_GAIN: current_b_gain_select <= acc_wdata[7:0];
				cvw_pkg::ADDR_CONFIG: config_reg <= acc_wdata[15:0];
				cvw_pkg::ADDR_PULSE1_DIVIDER: pulse1_divider <= acc_wdata[15:0];
				cvw_pkg::ADDR_PULSE2_DIVIDER: pulse2_divider <= acc_wdata[15:0];
				cvw_pkg::ADDR_PULSE_OUTPUT_SELECT: pulse_output_select <= acc_wdata[15:0];
				cvw_pkg::ADDR_PHASE_CAL_A: phase_cal_a <= acc_wdata[15:0];
				cvw_pkg::ADDR_PHASE_CAL_B: phase_cal_b <= acc_wdata[15:0];
				cvw_pkg::ADDR_ALTERNATE_OUTPUT: alternate_output_select <= acc_wdata[15:0];
				default: begin
					if (acc_addr[7:0] == cvw_pkg::LOW_ACCUMULATION_MODE) begin
						accumulation_mode <= acc_wdata[23:0];
					end else if (acc_addr[7:0] == cvw_pkg::LOW_CHANNEL_A_IRQ_ENABLE) begin
						channel_a_interrupt_enable <= acc_wdata[23:0];
					end else if (acc_addr[7:0] == cvw_pkg::LOW_CHANNEL_B_IRQ_ENABLE) begin
						channel_b_interrupt_enable <= acc_wdata[23:0];
					end else begin
						cal_store[cal_index(acc_addr[7:0])] <= acc_wdata[23:0];
					end
				end
			endcase
		end
	end

	// Record of the last successful access.
	always_ff @(posedge core_clk) begin
		if (clear_all) begin
			last_operation_type <= cvw_pkg::RESET_LAST_OPERATION;
			last_accessed_address <= cvw_pkg::RESET_HALF;
			last_transfer_data <= 32'h00000000;
		end else if (success) begin
			last_operation_type <= acc_write ? cvw_pkg::OP_WRITE : cvw_pkg::OP_READ;
			last_accessed_address <= acc_addr;
			last_transfer_data <= acc_write ? acc_wdata : rd_value;
		end
	end

	// Answer to the serial front end, one cycle after the request.
	always_ff @(posedge core_clk) begin
		if (clear_all) begin
			acc_done <= 1'b0;
			acc_ok <= 1'b0;
			acc_rdata <= 32'h00000000;
		end else begin
			acc_done <= acc_valid;
			acc_ok <= success;
			acc_rdata <= (acc_valid && !acc_write && success) ? rd_value : 32'h00000000;
		end
	end

	// Covered image; bit 0 enters the generator first.
	always_comb begin
		int pos;
		pos = 0;
		image = '0;
		image[pos +: 8] = line_cycle_mode;
		pos += 8;
		image[pos +: 8] = voltage_gain_select;
		pos += 8;
		image[pos +: 8] = current_a_gain_select;
		pos += 8;
		image[pos +: 8] = current_b_gain_select;
		pos += 8;
		image[pos +: 16] = config_reg;
		pos += 16;
		image[pos +: 16] = pulse1_divider;
		pos += 16;
		image[pos +: 16] = pulse2_divider;
		pos += 16;
		image[pos +: 16] = pulse_output_select;
		pos += 16;
		image[pos +: 16] = phase_cal_a;
		pos += 16;
		image[pos +: 16] = phase_cal_b;
		pos += 16;
		image[pos +: 16] = alternate_output_select;
		pos += 16;
		image[pos +: 24] = accumulation_mode;
		pos += 24;
		image[pos +: 24] = channel_a_interrupt_enable;
		pos += 24;
		image[pos +: 24] = channel_b_interrupt_enable;
		pos += 24;
		for (int i = 0; i < cvw_pkg::CAL_COUNT; i++) begin
			if (cvw_pkg::CAL_PRESENT[i]) begin
				image[pos +: 24] = cal_store[i];
				pos += 24;
			end
		end
		image[pos +: 8 * cvw_pkg::RESERVED_COUNT] = cvw_pkg::RESERVED_IMAGE;
	end

	assign checksum_enabled = config_reg[cvw_pkg::CHECKSUM_ENABLE_BIT];

	// Pass scheduler; a change during a pass leaves dirty set and forces another pass.
	always_ff @(posedge core_clk) begin
		if (clear_all || !checksum_enabled) begin
			state <= CVW_IDLE;
			dirty <= 1'b1;
			bit_idx <= '0;
		end else begin
			unique case (state)
				CVW_IDLE: begin
					bit_idx <= '0;
					if (dirty) begin
						state <= CVW_RUN;
						dirty <= covered_write;
					end else if (covered_write) begin
						dirty <= 1'b1;
					end
				end
				CVW_RUN: begin
					if (covered_write) begin
						dirty <= 1'b1;
					end
					bit_idx <= bit_idx + 1'b1;
					if (bit_idx == LAST_IDX) begin
						state <= CVW_FINISH;
					end
				end
				CVW_FINISH: begin
					if (covered_write) begin
						dirty <= 1'b1;
					end
					state <= CVW_IDLE;
				end
			endcase
		end
	end

	assign crc.clear = (state == CVW_IDLE);
	assign crc.shift = (state == CVW_RUN);
	assign crc.bit_in = image[bit_idx];

	always_ff @(posedge core_clk) begin
		if (clear_all || !checksum_enabled) begin
			config_checksum <= cvw_pkg::RESET_CHECKSUM;
		end else if (state == CVW_FINISH) begin
			config_checksum <= crc.value;
		end
	end

	// Snapshot taken as the checksum interrupt is enabled; pin low while it differs.
	always_ff @(posedge core_clk) begin
		if (clear_all) begin
			irq_enable_q <= 1'b0;
			irq_snapshot <= cvw_pkg::RESET_CHECKSUM;
			irq_n <= 1'b1;
		end else begin
			irq_enable_q <= channel_a_interrupt_enable[cvw_pkg::CHECKSUM_IRQ_BIT];
			if (channel_a_interrupt_enable[cvw_pkg::CHECKSUM_IRQ_BIT] && !irq_enable_q) begin
				irq_snapshot <= config_checksum;
			end
			irq_n <= !(irq_enable_q && channel_a_interrupt_enable[cvw_pkg::CHECKSUM_IRQ_BIT]
				&& config_checksum != irq_snapshot);
		end
	end
endmodule : cvw_reg_bank
